// File: fine_edge_pkg.sv
// Constants and types shared by the fine edge configuration block.
package fine_edge_pkg;
  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam int IDX_W = 6;
  localparam logic [5:0] IDX_PHASE_FINE = 6'h02;
  localparam logic [5:0] IDX_COMPARE_A_COARSE_FINE = 6'h08;
  localparam logic [5:0] IDX_CONFIG = 6'h20;
  localparam logic [5:0] IDX_PERMIT = 6'h21;
  localparam logic [5:0] IDX_STATUS = 6'h22;
  // ----------------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------------
  localparam int REG_W = 16;
  localparam int FINE_W = 8;
  localparam int FINE_LSB = 8;
  localparam int CFG_EDGE_LSB = 0;
  localparam int CFG_SRC_BIT = 2;
  localparam int CFG_LOAD_BIT = 3;
  localparam int PERMIT_BIT = 0;
  localparam int STS_ACTIVE_BIT = 0;
  localparam logic [7:0] FINE_RESET = 8'h00;
  localparam logic LOAD_ZERO = 1'b0;
  localparam logic LOAD_PERIOD = 1'b1;
  localparam logic SRC_DUTY = 1'b0;
  localparam logic SRC_PHASE = 1'b1;
  // ----------------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    EDGE_OFF = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_BOTH = 2'h3
  } edge_sel_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_ACK = 2'h1
  } bus_state_t;
endpackage : fine_edge_pkg

// File: fine_cfg_if.sv
// Carrier between the register front end and the fine value engine.
`timescale 1ns/1ps
`default_nettype none
interface fine_cfg_if;
  fine_edge_pkg::edge_sel_t edge_sel;
  logic src_phase;
  logic load_period;
  logic [7:0] compare_a_coarse_shadow;
  logic [7:0] phase_fine;
  logic ctr_zero;
  logic ctr_period;
  logic [7:0] compare_a_coarse_active;
  logic [7:0] rise_steps;
  logic [7:0] fall_steps;
  logic hr_active;
  modport front (output edge_sel, src_phase, load_period, compare_a_coarse_shadow, phase_fine,
    ctr_zero, ctr_period, input compare_a_coarse_active, rise_steps, fall_steps, hr_active);
  modport engine (input edge_sel, src_phase, load_period, compare_a_coarse_shadow, phase_fine,
    ctr_zero, ctr_period, output compare_a_coarse_active, rise_steps, fall_steps, hr_active);
endinterface : fine_cfg_if
`default_nettype wire

// File: fine_edge_engine.sv
// Shadow load of the compare fine value and per-edge step selection.
`timescale 1ns/1ps
`default_nettype none
module fine_edge_engine (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Configuration and results
  fine_cfg_if.engine cfg
);
  // ----------------------------------------------------------------------
  // Edge decoding
  // ----------------------------------------------------------------------
  function automatic logic edge_moved(input fine_edge_pkg::edge_sel_t sel, input logic rise);
    edge_moved = rise ? (sel == fine_edge_pkg::EDGE_RISE || sel == fine_edge_pkg::EDGE_BOTH)
                      : (sel == fine_edge_pkg::EDGE_FALL || sel == fine_edge_pkg::EDGE_BOTH);
  endfunction : edge_moved

  logic load_evt;
  logic [7:0] sel_val;

  // The period event counts only in duty control; phase control always loads on zero.
  assign load_evt = (cfg.src_phase == fine_edge_pkg::SRC_DUTY &&
                     cfg.load_period == fine_edge_pkg::LOAD_PERIOD) ? cfg.ctr_period
                                                                    : cfg.ctr_zero;
  assign sel_val = (cfg.src_phase == fine_edge_pkg::SRC_PHASE) ? cfg.phase_fine
                                                               : cfg.compare_a_coarse_active;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg.compare_a_coarse_active <= fine_edge_pkg::FINE_RESET;
    end else if (load_evt) begin
      cfg.compare_a_coarse_active <= cfg.compare_a_coarse_shadow;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg.rise_steps <= fine_edge_pkg::FINE_RESET;
      cfg.fall_steps <= fine_edge_pkg::FINE_RESET;
      cfg.hr_active <= 1'b0;
    end else begin
      cfg.rise_steps <= edge_moved(cfg.edge_sel, 1'b1) ? sel_val : '0;
      cfg.fall_steps <= edge_moved(cfg.edge_sel, 1'b0) ? sel_val : '0;
      cfg.hr_active <= (cfg.edge_sel != fine_edge_pkg::EDGE_OFF) && (sel_val != '0);
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_load_on_zero;
    @(posedge clk_i) disable iff (rst_i)
    cfg.ctr_zero && !cfg.ctr_period && (cfg.src_phase || !cfg.load_period)
    |=> cfg.compare_a_coarse_active == $past(cfg.compare_a_coarse_shadow);
  endproperty
  a_load_on_zero: assert property (p_load_on_zero) else $error("zero load missed");

  property p_phase_ignores_select;
    @(posedge clk_i) disable iff (rst_i)
    cfg.src_phase && cfg.load_period && cfg.ctr_period && !cfg.ctr_zero
    |=> $stable(cfg.compare_a_coarse_active);
  endproperty
  a_phase_ignores_select: assert property (p_phase_ignores_select)
    else $error("period load in phase mode");

  property p_edge_off;
    @(posedge clk_i) disable iff (rst_i)
    cfg.edge_sel == fine_edge_pkg::EDGE_OFF |=> cfg.rise_steps == '0 && cfg.fall_steps == '0
      && !cfg.hr_active;
  endproperty
  a_edge_off: assert property (p_edge_off) else $error("fine delay while disabled");

  property p_rise_only;
    @(posedge clk_i) disable iff (rst_i)
    cfg.edge_sel == fine_edge_pkg::EDGE_RISE && cfg.src_phase
    |=> cfg.fall_steps == '0 && cfg.rise_steps == $past(cfg.phase_fine);
  endproperty
  a_rise_only: assert property (p_rise_only) else $error("rise-only edge wrong");

  property p_duty_source;
    @(posedge clk_i) disable iff (rst_i)
    cfg.edge_sel == fine_edge_pkg::EDGE_BOTH && !cfg.src_phase
    |=> cfg.fall_steps == $past(cfg.compare_a_coarse_active) && cfg.rise_steps == cfg.fall_steps;
  endproperty
  a_duty_source: assert property (p_duty_source) else $error("duty source wrong");

  c_period_load: cover property (@(posedge clk_i) disable iff (rst_i)
    !cfg.src_phase && cfg.load_period && cfg.ctr_period ##1 cfg.compare_a_coarse_active != '0);
endmodule : fine_edge_engine
`default_nettype wire

// File: fine_edge_pwm_config.sv
// Wishbone register front end of the fine edge extension for PWM channel A.
`timescale 1ns/1ps
`default_nettype none
module fine_edge_pwm_config (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Time base events and coarse output
  input wire logic ctr_zero_i,
  input wire logic ctr_period_i,
  input wire logic coarse_a_i,
  // Micro edge positioner drive
  output logic chan_a_o,
  output logic [7:0] rise_steps_o,
  output logic [7:0] fall_steps_o,
  output logic hr_active_o
);
  fine_cfg_if cfg ();

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  fine_edge_pkg::bus_state_t state;
  fine_edge_pkg::edge_sel_t edge_sel;
  logic src_phase;
  logic load_period;
  logic [7:0] compare_a_coarse_fine;
  logic [7:0] phase_fine;
  logic permit;
  logic [5:0] idx;
  logic wr_stb;
  logic [15:0] wmask;
  logic [15:0] next_cfg;

  assign idx = adr_i[7:2];
  assign wmask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
  assign wr_stb = cyc_i && stb_i && we_i && ack_o;

  // ----------------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------------
  // Ack comes one cycle after the request and falls in the cycle after.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= fine_edge_pkg::BUS_IDLE;
    end else begin
      case (state)
        fine_edge_pkg::BUS_IDLE: begin
          if (cyc_i && stb_i) begin
            state <= fine_edge_pkg::BUS_ACK;
          end
        end
        fine_edge_pkg::BUS_ACK: begin
          state <= fine_edge_pkg::BUS_IDLE;
        end
        default: begin
          state <= fine_edge_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  assign ack_o = (state == fine_edge_pkg::BUS_ACK);

  // Read data is captured when the request is first seen.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= '0;
    end else if (cyc_i && stb_i && !ack_o) begin
      dat_o <= '0;
      case (idx)
        fine_edge_pkg::IDX_PHASE_FINE: begin
          dat_o[fine_edge_pkg::FINE_LSB +: fine_edge_pkg::FINE_W] <= phase_fine;
        end
        fine_edge_pkg::IDX_COMPARE_A_COARSE_FINE: begin
          dat_o[fine_edge_pkg::FINE_LSB +: fine_edge_pkg::FINE_W] <= compare_a_coarse_fine;
        end
        fine_edge_pkg::IDX_CONFIG: begin
          dat_o[fine_edge_pkg::CFG_EDGE_LSB +: 2] <= edge_sel;
          dat_o[fine_edge_pkg::CFG_SRC_BIT] <= src_phase;
          dat_o[fine_edge_pkg::CFG_LOAD_BIT] <= load_period;
        end
        fine_edge_pkg::IDX_PERMIT: begin
          dat_o[fine_edge_pkg::PERMIT_BIT] <= permit;
        end
        fine_edge_pkg::IDX_STATUS: begin
          dat_o[fine_edge_pkg::STS_ACTIVE_BIT] <= cfg.hr_active;
          dat_o[fine_edge_pkg::FINE_LSB +: fine_edge_pkg::FINE_W] <= cfg.compare_a_coarse_active;
        end
        default: begin
          dat_o <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always_comb begin
    next_cfg = {12'h000, load_period, src_phase, edge_sel};
    next_cfg = (next_cfg & ~wmask) | (dat_i[15:0] & wmask);
  end

  // Configuration is protected: writes without the permit are dropped.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      edge_sel <= fine_edge_pkg::EDGE_OFF;
      src_phase <= fine_edge_pkg::SRC_DUTY;
      load_period <= fine_edge_pkg::LOAD_ZERO;
    end else if (wr_stb && idx == fine_edge_pkg::IDX_CONFIG && permit) begin
      edge_sel <= fine_edge_pkg::edge_sel_t'(next_cfg[fine_edge_pkg::CFG_EDGE_LSB +: 2]);
      src_phase <= next_cfg[fine_edge_pkg::CFG_SRC_BIT];
      load_period <= next_cfg[fine_edge_pkg::CFG_LOAD_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      permit <= 1'b0;
    end else if (wr_stb && idx == fine_edge_pkg::IDX_PERMIT && sel_i[0]) begin
      permit <= dat_i[fine_edge_pkg::PERMIT_BIT];
    end
  end

  // Only the high byte is stored; the low byte is not held at all.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_a_coarse_fine <= fine_edge_pkg::FINE_RESET;
      phase_fine <= fine_edge_pkg::FINE_RESET;
    end else if (wr_stb && sel_i[1]) begin
      if (idx == fine_edge_pkg::IDX_COMPARE_A_COARSE_FINE) begin
        compare_a_coarse_fine <= dat_i[fine_edge_pkg::FINE_LSB +: fine_edge_pkg::FINE_W];
      end
      if (idx == fine_edge_pkg::IDX_PHASE_FINE) begin
        phase_fine <= dat_i[fine_edge_pkg::FINE_LSB +: fine_edge_pkg::FINE_W];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Engine and outputs
  // ----------------------------------------------------------------------
  assign cfg.edge_sel = edge_sel;
  assign cfg.src_phase = src_phase;
  assign cfg.load_period = load_period;
  assign cfg.compare_a_coarse_shadow = compare_a_coarse_fine;
  assign cfg.phase_fine = phase_fine;
  assign cfg.ctr_zero = ctr_zero_i;
  assign cfg.ctr_period = ctr_period_i;

  fine_edge_engine u_engine (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cfg(cfg)
  );

  // The coarse edge is retimed only; any fine delay is added downstream.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_a_o <= 1'b0;
    end else begin
      chan_a_o <= coarse_a_i;
    end
  end

  assign rise_steps_o = cfg.rise_steps;
  assign fall_steps_o = cfg.fall_steps;
  assign hr_active_o = cfg.hr_active;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_protect;
    @(posedge clk_i) disable iff (rst_i)
    wr_stb && idx == fine_edge_pkg::IDX_CONFIG && !permit
    |=> $stable(edge_sel) && $stable(src_phase) && $stable(load_period);
  endproperty
  a_protect: assert property (p_protect) else $error("protected write accepted");

  property p_permitted_write;
    @(posedge clk_i) disable iff (rst_i)
    wr_stb && idx == fine_edge_pkg::IDX_CONFIG && permit && sel_i[0]
    |=> edge_sel == $past(dat_i[1:0]) && load_period == $past(dat_i[3]);
  endproperty
  a_permitted_write: assert property (p_permitted_write)
    else $error("permitted write lost");

  property p_low_byte_zero;
    @(posedge clk_i) disable iff (rst_i)
    ack_o && (idx == fine_edge_pkg::IDX_COMPARE_A_COARSE_FINE || idx == fine_edge_pkg::IDX_PHASE_FINE)
    |-> dat_o[7:0] == 8'h00;
  endproperty
  a_low_byte_zero: assert property (p_low_byte_zero) else $error("low byte not zero");

  property p_fine_write;
    @(posedge clk_i) disable iff (rst_i)
    wr_stb && sel_i[1] && idx == fine_edge_pkg::IDX_COMPARE_A_COARSE_FINE
    |=> compare_a_coarse_fine == $past(dat_i[15:8]) ##1 1'b1;
  endproperty
  a_fine_write: assert property (p_fine_write) else $error("fine value not stored");

  property p_coarse_pass;
    @(posedge clk_i) disable iff (rst_i)
    edge_sel == fine_edge_pkg::EDGE_OFF ##1 1'b1
    |-> chan_a_o == $past(coarse_a_i) && rise_steps_o == '0 && fall_steps_o == '0;
  endproperty
  a_coarse_pass: assert property (p_coarse_pass) else $error("coarse edge altered");

  property p_ack_single;
    @(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
  endproperty
  a_ack_single: assert property (p_ack_single) else $error("ack timing wrong");

  c_protect_drop: cover property (@(posedge clk_i) disable iff (rst_i)
    wr_stb && idx == fine_edge_pkg::IDX_CONFIG && !permit);
  c_hr_active: cover property (@(posedge clk_i) disable iff (rst_i) hr_active_o);
  c_phase_mode: cover property (@(posedge clk_i) disable iff (rst_i)
    src_phase && rise_steps_o != '0);
endmodule : fine_edge_pwm_config
`default_nettype wire

// File: fine_tb_timebase.sv
// Up-down time base model that feeds counter events and a coarse channel A level.
`timescale 1ns/1ps
`default_nettype none
module fine_tb_timebase #(
  parameter int PERIOD = 20,
  parameter int LEVEL = 7
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Time base events and coarse output
  output logic ctr_zero_o,
  output logic ctr_period_o,
  output logic coarse_a_o
);
  logic [7:0] cnt;
  logic down;
  // Counting up and down keeps a full half period between zero and period events.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 8'h00;
      down <= 1'b0;
    end else if (!down) begin
      if (cnt == 8'(PERIOD - 1)) down <= 1'b1;
      cnt <= cnt + 8'h01;
    end else begin
      if (cnt == 8'h01) down <= 1'b0;
      cnt <= cnt - 8'h01;
    end
  end
  assign ctr_zero_o = (cnt == 8'h00) && !rst_i;
  assign ctr_period_o = (cnt == 8'(PERIOD)) && !rst_i;
  assign coarse_a_o = (cnt < 8'(LEVEL));
endmodule : fine_tb_timebase
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the fine edge register block and its time base partner.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {logic [3:0] cfg; logic [7:0] rise; logic [7:0] fall; logic hr;} row_t;
  localparam logic [7:0] A_PH = {fine_edge_pkg::IDX_PHASE_FINE, 2'b00};
  localparam logic [7:0] A_CA = {fine_edge_pkg::IDX_COMPARE_A_COARSE_FINE, 2'b00};
  localparam logic [7:0] A_CFG = {fine_edge_pkg::IDX_CONFIG, 2'b00};
  localparam logic [7:0] A_PRM = {fine_edge_pkg::IDX_PERMIT, 2'b00};
  localparam logic [7:0] A_ST = {fine_edge_pkg::IDX_STATUS, 2'b00};
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, coarse_a_i, ctr_zero_i, ctr_period_i;
  logic chan_a_o, hr_active_o, prev_a, past_rst;
  logic [7:0] adr_i, rise_steps_o, fall_steps_o;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rd;
  int n_mismatch = 0;
  int num_checks = 0;
  logic [7:0] rst_adr [5] = '{A_PH, A_CA, A_CFG, A_ST, 8'hfc};
  // Active compare value 0x5a, phase value 0xc3, load on zero.
  row_t rows [8] = '{'{4'h0, 8'h00, 8'h00, 1'b0}, '{4'h1, 8'h5a, 8'h00, 1'b1},
    '{4'h2, 8'h00, 8'h5a, 1'b1}, '{4'h3, 8'h5a, 8'h5a, 1'b1}, '{4'h4, 8'h00, 8'h00, 1'b0},
    '{4'h5, 8'hc3, 8'h00, 1'b1}, '{4'h6, 8'h00, 8'hc3, 1'b1}, '{4'h7, 8'hc3, 8'hc3, 1'b1}};

  fine_edge_pwm_config dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .ctr_zero_i(ctr_zero_i), .ctr_period_i(ctr_period_i), .coarse_a_i(coarse_a_i),
    .chan_a_o(chan_a_o), .rise_steps_o(rise_steps_o), .fall_steps_o(fall_steps_o),
    .hr_active_o(hr_active_o));
  fine_tb_timebase #(.PERIOD(20), .LEVEL(7)) tb_u (.clk_i(clk_i), .rst_i(rst_i),
    .ctr_zero_o(ctr_zero_i), .ctr_period_o(ctr_period_i), .coarse_a_o(coarse_a_i));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One classic cycle; entered just after a rising edge, leaves just after one.
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {16'h0000, d};
    sel_i <= 4'h3;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    chk(ack_o, 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  // Waits for a zero (0) or period (1) event, then lets the outputs settle.
  task automatic wait_ev(input logic per);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while ((per ? ctr_period_i : ctr_zero_i) !== 1'b1 && n < 100);
    repeat (3) @(posedge clk_i);
  endtask : wait_ev

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------------
  // Clock, pass-through monitor and watchdog
  // ----------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (!rst_i && !past_rst) chk(chan_a_o, prev_a);
    past_rst = rst_i;
    prev_a = coarse_a_i;
  end

  initial begin
    #(8 * 40000);
    n_mismatch++;
    $display("BAD %0t timeout", $time);
    finish_test();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    past_rst = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'h0;
    dat_i = 32'h0000_0000;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({hr_active_o, rise_steps_o, fall_steps_o}, 32'h0);
    foreach (rst_adr[i]) begin
      wb(1'b0, rst_adr[i], 16'h0000);
      chk(rd, 32'h0);
    end
    wb(1'b1, A_CFG, 16'h0003);
    wb(1'b0, A_CFG, 16'h0000);
    chk(rd, 32'h0);
    wb(1'b1, A_PRM, 16'h0001);
    wb(1'b1, A_CFG, 16'h0003);
    wb(1'b0, A_CFG, 16'h0000);
    chk(rd, 32'h3);
    wb(1'b1, A_PRM, 16'h0000);
    wb(1'b1, A_CFG, 16'h0000);
    wb(1'b0, A_CFG, 16'h0000);
    chk(rd, 32'h3);
    wb(1'b1, A_PRM, 16'h0001);
    wb(1'b1, A_CA, 16'h5aff);
    wb(1'b0, A_CA, 16'h0000);
    chk(rd, 32'h5a00);
    wb(1'b1, A_PH, 16'hc377);
    wb(1'b0, A_PH, 16'h0000);
    chk(rd, 32'hc300);
    wait_ev(1'b0);
    wb(1'b0, A_ST, 16'h0000);
    chk(rd, 32'h5a01);
    foreach (rows[i]) begin
      wb(1'b1, A_CFG, {12'h000, rows[i].cfg});
      repeat (2) @(posedge clk_i);
      chk({hr_active_o, rise_steps_o, fall_steps_o}, {rows[i].hr, rows[i].rise, rows[i].fall});
    end
    wb(1'b1, A_PH, 16'h0000);
    repeat (2) @(posedge clk_i);
    chk({hr_active_o, rise_steps_o}, 9'h0);
    // Load on period, matching a coarse load-on-period mode.
    wb(1'b1, A_CFG, 16'h0009);
    wait_ev(1'b1);
    wb(1'b1, A_CA, 16'h3100);
    wait_ev(1'b0);
    chk(rise_steps_o, 8'h5a);
    wait_ev(1'b1);
    chk(rise_steps_o, 8'h31);
    wb(1'b1, A_CFG, 16'h0001);
    wait_ev(1'b0);
    wb(1'b1, A_CA, 16'h7e00);
    wait_ev(1'b1);
    chk(rise_steps_o, 8'h31);
    wait_ev(1'b0);
    chk(rise_steps_o, 8'h7e);
    // Phase control ignores the period selection.
    wb(1'b1, A_PH, 16'h4400);
    wb(1'b1, A_CFG, 16'h000d);
    wait_ev(1'b1);
    wb(1'b1, A_CA, 16'h2200);
    wait_ev(1'b0);
    chk(rise_steps_o, 8'h44);
    wb(1'b0, A_ST, 16'h0000);
    chk(rd[15:8], 8'h22);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, A_CFG, 16'h0000);
    chk(rd, 32'h0);
    chk({hr_active_o, rise_steps_o, fall_steps_o}, 32'h0);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
